/* pkg/dcrb_defines.svh */
// constants for the data cache request, combining and bank block
`ifndef DCRB_DEFINES_SVH
`define DCRB_DEFINES_SVH
`define DCRB_AW 32
`define DCRB_LINE_BYTES 64
`define DCRB_OFS_W 6
`define DCRB_LINE_W 26
`define DCRB_MSHR_N 8
`define DCRB_MSHR_IW 3
`define DCRB_BANK_N 8
`define DCRB_BANK_LO 3
`define DCRB_BANK_HI 5
`define DCRB_IDX_LO 6
`define DCRB_IDX_HI 11
`define DCRB_WC_N 4
`define DCRB_WC_IW 2
`endif

/* pkg/dcrb_pkg.sv */
// types for the data cache request, combining and bank block
package dcrb_pkg;
  typedef enum logic [2:0] {
    DCRB_IDLE = 3'h1,
    DCRB_DRAIN = 3'h2,
    DCRB_DONE = 3'h4
  } dcrb_fence_e;
  typedef struct packed {
    logic [7:0] mshr_vld;
    logic [7:0][25:0] mshr_line;
    logic [3:0] wc_vld;
    logic [3:0][25:0] wc_line;
    logic [3:0][63:0] wc_be;
    logic [3:0][511:0] wc_data;
    logic [3:0][1:0] wc_age;
    logic wr_vld;
    logic [25:0] wr_line;
    logic [63:0] wr_be;
    logic [511:0] wr_data;
    dcrb_fence_e fence;
  } dcrb_state_s;
endpackage

/* hdl/dcrb_core.sv */
// data cache front end: miss tracking, write combining, bank arbitration
`timescale 1ns/1ps
`include "dcrb_defines.svh"
module dcrb_core (
  input wire logic mclk,
  input wire logic rst,
  // miss or prefetch request from the pipeline
  input wire logic req_vld,
  input wire logic [`DCRB_AW-1:0] req_addr,
  input wire logic req_pf,
  input wire logic req_wint,
  output logic req_rdy,
  // address of a store still pending ahead of the cache
  input wire logic st_pend,
  input wire logic [`DCRB_AW-1:0] st_pend_addr,
  // line read to memory
  output logic mrd_vld,
  output logic [`DCRB_LINE_W-1:0] mrd_line,
  output logic mrd_modified,
  output logic [`DCRB_MSHR_IW-1:0] mrd_tag,
  input wire logic mrd_rdy,
  // fill return frees a tracking entry
  input wire logic fill_vld,
  input wire logic [`DCRB_MSHR_IW-1:0] fill_tag,
  // streaming store
  input wire logic ss_vld,
  input wire logic [`DCRB_AW-1:0] ss_addr,
  input wire logic [63:0] ss_data,
  input wire logic [7:0] ss_be,
  output logic ss_rdy,
  // fence
  input wire logic fence_vld,
  output logic fence_done,
  // line write to memory, no allocation
  output logic mwr_vld,
  output logic [`DCRB_LINE_W-1:0] mwr_line,
  output logic [511:0] mwr_data,
  output logic [63:0] mwr_be,
  input wire logic mwr_rdy,
  // two loads, first older
  input wire logic ld0_vld,
  input wire logic [`DCRB_AW-1:0] ld0_addr,
  input wire logic ld1_vld,
  input wire logic [`DCRB_AW-1:0] ld1_addr,
  output logic ld0_go,
  output logic ld1_go,
  output logic [`DCRB_BANK_N-1:0] ld0_bank_sel,
  output logic [`DCRB_BANK_N-1:0] ld1_bank_sel
);
  dcrb_pkg::dcrb_state_s st;
  dcrb_pkg::dcrb_state_s next_st;

  function automatic logic [2:0] bank_of(input logic [`DCRB_AW-1:0] a);
    bank_of = a[`DCRB_BANK_HI:`DCRB_BANK_LO];
  endfunction
  function automatic logic [5:0] idx_of(input logic [`DCRB_AW-1:0] a);
    idx_of = a[`DCRB_IDX_HI:`DCRB_IDX_LO];
  endfunction
  function automatic logic [`DCRB_LINE_W-1:0] line_of(
    input logic [`DCRB_AW-1:0] a);
    line_of = a[`DCRB_AW-1:`DCRB_OFS_W];
  endfunction

  logic [`DCRB_LINE_W-1:0] rline;
  logic hit_any;
  logic has_free;
  logic [`DCRB_MSHR_IW-1:0] free_i;
  logic pf_block;
  logic conflict;
  logic [`DCRB_LINE_W-1:0] sline;
  logic ss_hit;
  logic [`DCRB_WC_IW-1:0] ss_hit_i;
  logic wc_free;
  logic [`DCRB_WC_IW-1:0] wc_free_i;
  logic [`DCRB_WC_IW-1:0] oldest_i;
  logic [`DCRB_WC_IW-1:0] fl_i;
  logic wr_take;

  always_comb
  begin
    rline = line_of(req_addr);
    hit_any = 1'b0;
    has_free = 1'b0;
    free_i = '0;
    for (int i = `DCRB_MSHR_N - 1; i >= 0; i--)
    begin
      if (st.mshr_vld[i] && st.mshr_line[i] == rline)
        hit_any = 1'b1;
      if (!st.mshr_vld[i])
      begin
        has_free = 1'b1;
        free_i = i[`DCRB_MSHR_IW-1:0];
      end
    end
    // hazard: prefetch must not overtake a store to same line
    pf_block = req_pf && st_pend &&
      line_of(st_pend_addr) == rline;
    // in-order single port keeps prefetches in issue order
    req_rdy = !pf_block && (hit_any || (has_free && mrd_rdy));
    mrd_vld = req_vld && !pf_block && !hit_any && has_free;
    mrd_line = rline;
    mrd_modified = req_wint;
    mrd_tag = free_i;
  end

  // bank conflict arbitration
  always_comb
  begin
    conflict = bank_of(ld0_addr) == bank_of(ld1_addr) &&
      idx_of(ld0_addr) != idx_of(ld1_addr);
    ld0_go = ld0_vld;
    ld1_go = ld0_vld && ld1_vld && !conflict;
    ld0_bank_sel = 8'h01 << bank_of(ld0_addr);
    ld1_bank_sel = 8'h01 << bank_of(ld1_addr);
  end

  // write combining lookup
  always_comb
  begin
    sline = line_of(ss_addr);
    ss_hit = 1'b0;
    ss_hit_i = '0;
    wc_free = 1'b0;
    wc_free_i = '0;
    oldest_i = '0;
    fl_i = '0;
    for (int i = `DCRB_WC_N - 1; i >= 0; i--)
    begin
      if (st.wc_vld[i] && st.wc_line[i] == sline)
      begin
        ss_hit = 1'b1;
        ss_hit_i = i[`DCRB_WC_IW-1:0];
      end
      if (!st.wc_vld[i])
      begin
        wc_free = 1'b1;
        wc_free_i = i[`DCRB_WC_IW-1:0];
      end
      if (st.wc_age[i] == 2'(`DCRB_WC_N - 1))
        oldest_i = i[`DCRB_WC_IW-1:0];
      if (st.wc_vld[i])
        fl_i = i[`DCRB_WC_IW-1:0];
    end
    wr_take = !st.wr_vld || mwr_rdy;
    // stores wait while a fence drains
    ss_rdy = st.fence == dcrb_pkg::DCRB_IDLE &&
      (ss_hit || wc_free || wr_take);
    mwr_vld = st.wr_vld;
    mwr_line = st.wr_line;
    mwr_data = st.wr_data;
    mwr_be = st.wr_be;
    fence_done = st.fence == dcrb_pkg::DCRB_DONE;
  end

  always_comb
  begin
    logic [`DCRB_WC_IW-1:0] slot;
    logic alloc;
    logic evict;
    slot = '0;
    alloc = 1'b0;
    evict = 1'b0;
    next_st = st;
    // entry freed by fill; a same-cycle allocation uses another slot
    if (fill_vld)
      next_st.mshr_vld[fill_tag] = 1'b0;
    if (mrd_vld && mrd_rdy)
    begin
      next_st.mshr_vld[free_i] = 1'b1;
      next_st.mshr_line[free_i] = rline;
    end
    if (st.wr_vld && mwr_rdy)
      next_st.wr_vld = 1'b0;
    if (ss_vld && ss_rdy)
    begin
      if (ss_hit)
        slot = ss_hit_i;
      else if (wc_free)
      begin
        slot = wc_free_i;
        alloc = 1'b1;
      end
      else
      begin
        slot = oldest_i;
        alloc = 1'b1;
        evict = 1'b1;
      end
      if (evict)
      begin
        next_st.wr_vld = 1'b1;
        next_st.wr_line = st.wc_line[slot];
        next_st.wr_be = st.wc_be[slot];
        next_st.wr_data = st.wc_data[slot];
      end
      if (alloc)
      begin
        // age the others, newcomer is youngest
        for (int i = 0; i < `DCRB_WC_N; i++)
          if (st.wc_vld[i] && i[`DCRB_WC_IW-1:0] != slot &&
              st.wc_age[i] != 2'(`DCRB_WC_N - 1))
            next_st.wc_age[i] = st.wc_age[i] + 2'h1;
        next_st.wc_age[slot] = '0;
        next_st.wc_vld[slot] = 1'b1;
        next_st.wc_line[slot] = sline;
        next_st.wc_be[slot] = '0;
      end
      for (int b = 0; b < 8; b++)
        if (ss_be[b])
        begin
          next_st.wc_be[slot][{bank_of(ss_addr), 3'(b)}] = 1'b1;
          next_st.wc_data[slot][{bank_of(ss_addr), 3'(b), 3'h0} +: 8] =
            ss_data[b*8 +: 8];
        end
    end
    case (st.fence)
      dcrb_pkg::DCRB_IDLE:
        if (fence_vld)
          next_st.fence = dcrb_pkg::DCRB_DRAIN;
      dcrb_pkg::DCRB_DRAIN:
        if (st.wc_vld == '0 && !st.wr_vld)
          next_st.fence = dcrb_pkg::DCRB_DONE;
        else if (st.wc_vld != '0 && wr_take)
        begin
          next_st.wr_vld = 1'b1;
          next_st.wr_line = st.wc_line[fl_i];
          next_st.wr_be = st.wc_be[fl_i];
          next_st.wr_data = st.wc_data[fl_i];
          next_st.wc_vld[fl_i] = 1'b0;
          next_st.wc_age[fl_i] = '0;
        end
      dcrb_pkg::DCRB_DONE:
        next_st.fence = dcrb_pkg::DCRB_IDLE;
      default:
        next_st.fence = dcrb_pkg::DCRB_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.fence <= dcrb_pkg::DCRB_IDLE;
    end
    else
      st <= next_st;
  end

  // count of live tracking entries, for checking only
  logic [3:0] mshr_cnt;
  always_comb
  begin
    mshr_cnt = '0;
    for (int i = 0; i < `DCRB_MSHR_N; i++)
      mshr_cnt = mshr_cnt + {3'h0, st.mshr_vld[i]};
  end

  mshr_limit_a: assert property (@(posedge mclk) disable iff (rst)
    mrd_vld && mrd_rdy |-> mshr_cnt < 4'(`DCRB_MSHR_N))
    else $error("too many outstanding lines");
  mshr_merge_a: assert property (@(posedge mclk) disable iff (rst)
    req_vld && hit_any |-> !mrd_vld && req_rdy)
    else $error("same line request not merged");
  full_stall_a: assert property (@(posedge mclk) disable iff (rst)
    req_vld && !hit_any && st.mshr_vld == 8'hFF |-> !req_rdy)
    else $error("request taken while tracker full");
  pf_hold_a: assert property (@(posedge mclk) disable iff (rst)
    pf_block |-> !mrd_vld && !req_rdy)
    else $error("prefetch passed pending store");
  wint_mod_a: assert property (@(posedge mclk) disable iff (rst)
    mrd_vld |-> mrd_modified == req_wint)
    else $error("write intent not marked modified");
  wc_merge_a: assert property (@(posedge mclk) disable iff (rst)
    ss_vld && ss_rdy && ss_hit |=> $stable(st.wc_vld))
    else $error("same line store took a new buffer");
  fence_flush_a: assert property (@(posedge mclk) disable iff (rst)
    fence_done |-> st.wc_vld == '0 && !st.wr_vld)
    else $error("fence done with buffers pending");
  bank_pair_a: assert property (@(posedge mclk) disable iff (rst)
    ld0_vld && ld1_vld && !conflict |-> ld0_go && ld1_go)
    else $error("non conflicting pair not issued");
  bank_conf_a: assert property (@(posedge mclk) disable iff (rst)
    conflict |-> !ld1_go)
    else $error("conflicting loads issued together");
  load_order_a: assert property (@(posedge mclk) disable iff (rst)
    ld1_go |-> ld0_go)
    else $error("younger load issued alone");
  evict_old_a: assert property (@(posedge mclk) disable iff (rst)
    ss_vld && ss_rdy && !ss_hit && !wc_free |=>
    mwr_vld && mwr_line == $past(st.wc_line[oldest_i]))
    else $error("eviction did not pick oldest");

  pair_c: cover property (@(posedge mclk) ld0_go && ld1_go);
  full_c: cover property (@(posedge mclk) st.mshr_vld == 8'hFF);
  fence_c: cover property (@(posedge mclk) fence_done);
  evict_c: cover property (@(posedge mclk)
    ss_vld && ss_rdy && !ss_hit && !wc_free);
endmodule

/* bench/dcrb_mem_model.sv */
// memory side model: accepts line reads, returns fills, takes line writes
`timescale 1ns/1ps
module dcrb_mem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fill_en,
  input wire logic wr_en,
  input wire logic mrd_vld,
  input wire logic [2:0] mrd_tag,
  output logic mrd_rdy,
  output logic fill_vld,
  output logic [2:0] fill_tag,
  output logic mwr_rdy
);
  logic [2:0] tags[$];
  assign mrd_rdy = 1'b1;
  assign mwr_rdy = wr_en;
  always @(posedge mclk or posedge rst)
    if (rst)
    begin
      tags.delete();
      fill_vld <= 1'b0;
      fill_tag <= 3'h0;
    end
    else
    begin
      if (mrd_vld && mrd_rdy)
        tags.push_back(mrd_tag);
      fill_vld <= 1'b0;
      // idle tag keeps moving so a stale value is never trusted
      fill_tag <= ~fill_tag;
      if (fill_en && tags.size() > 0)
      begin
        fill_vld <= 1'b1;
        fill_tag <= tags.pop_front();
      end
    end
endmodule

/* bench/dcache_request_bank_wc_logic_test.sv */
// testbench for the data cache request, combining and bank block
`timescale 1ns/1ps
module dcache_request_bank_wc_logic_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_vld, req_pf, req_wint, st_pend, ss_vld, fence_vld, ld0_vld;
  logic ld1_vld, fill_en, wr_en, req_rdy, mrd_vld, mrd_modified, mrd_rdy;
  logic fill_vld, ss_rdy, fence_done, mwr_vld, mwr_rdy, ld0_go, ld1_go;
  logic [31:0] req_addr, st_pend_addr, ss_addr, ld0_addr, ld1_addr;
  logic [63:0] ss_data, mwr_be;
  logic [7:0] ss_be, ld0_bank_sel, ld1_bank_sel;
  logic [25:0] mrd_line, mwr_line;
  logic [2:0] mrd_tag, fill_tag;
  logic [511:0] mwr_data;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] tag_seen = 8'h00;
  always #5 mclk = ~mclk;
  dcrb_core dut (.mclk, .rst, .req_vld, .req_addr, .req_pf, .req_wint,
    .req_rdy, .st_pend, .st_pend_addr, .mrd_vld, .mrd_line, .mrd_modified,
    .mrd_tag, .mrd_rdy, .fill_vld, .fill_tag, .ss_vld, .ss_addr, .ss_data,
    .ss_be, .ss_rdy, .fence_vld, .fence_done, .mwr_vld, .mwr_line,
    .mwr_data, .mwr_be, .mwr_rdy, .ld0_vld, .ld0_addr, .ld1_vld, .ld1_addr,
    .ld0_go, .ld1_go, .ld0_bank_sel, .ld1_bank_sel);
  dcrb_mem_model mem (.mclk, .rst, .fill_en, .wr_en, .mrd_vld, .mrd_tag,
    .mrd_rdy, .fill_vld, .fill_tag, .mwr_rdy);
  task automatic chk(input string n, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task complete_run;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      complete_run;
    end
  end
  // request stands until taken or n samples refused
  task automatic req(input logic [31:0] a, input logic pf, w, input int n,
    output logic r, m, mo);
    @(posedge mclk);
    req_vld <= 1'b1;
    req_addr <= a;
    req_pf <= pf;
    req_wint <= w;
    r = 1'b0;
    for (int i = 0; i < n && r !== 1'b1; i++)
    begin
      @(negedge mclk);
      r = req_rdy;
      m = mrd_vld;
      mo = mrd_modified;
      if (m === 1'b1) chk("mrd_line", mrd_line, a[31:6]);
      if (m === 1'b1) tag_seen |= 8'h01 << mrd_tag;
      if (r !== 1'b1 && i < n - 1) @(posedge mclk);
    end
    @(posedge mclk);
    req_vld <= 1'b0;
  endtask
  task automatic st(input logic [31:0] a, input logic [63:0] d,
    input logic [7:0] be);
    @(posedge mclk);
    ss_vld <= 1'b1;
    ss_addr <= a;
    ss_data <= d;
    ss_be <= be;
    @(negedge mclk);
    for (int i = 0; i < 30 && ss_rdy !== 1'b1; i++) @(negedge mclk);
    chk("ss_rdy", ss_rdy, 1'b1);
    chk("no_fetch", mrd_vld, 1'b0);
    @(posedge mclk);
    ss_vld <= 1'b0;
  endtask
  task automatic wait_mwr;
    @(negedge mclk);
    for (int i = 0; i < 30 && mwr_vld !== 1'b1; i++) @(negedge mclk);
    chk("mwr_vld", mwr_vld, 1'b1);
  endtask
  // waits out a fence already taken; a second fence would be ignored
  task automatic fence_end(input int writes);
    repeat (writes)
    begin
      wait_mwr;
      @(posedge mclk);
    end
    @(negedge mclk);
    for (int i = 0; i < 30 && fence_done !== 1'b1; i++) @(negedge mclk);
    chk("fence_done", fence_done, 1'b1);
    chk("drained", mwr_vld, 1'b0);
  endtask
  task automatic fence_wait(input int writes);
    @(posedge mclk);
    fence_vld <= 1'b1;
    @(posedge mclk);
    fence_vld <= 1'b0;
    fence_end(writes);
  endtask
  task automatic t_track;
    logic r, m, mo;
    for (int i = 0; i < 8; i++)
    begin
      req(32'h1000 + i * 64, 1'b1, 1'b0, 1, r, m, mo);
      chk("issue", {r, m}, 2'b11);
    end
    chk("tags", tag_seen, 8'hFF);
    req(32'h1008, 1'b0, 1'b0, 1, r, m, mo);
    chk("merge", {r, m}, 2'b10);
    req(32'h2000, 1'b0, 1'b0, 1, r, m, mo);
    chk("full", r, 1'b0);
    fill_en <= 1'b1;
    req(32'h2000, 1'b0, 1'b0, 20, r, m, mo);
    chk("freed", {r, m}, 2'b11);
    chk("not_mod", mo, 1'b0);
    req(32'h3000, 1'b1, 1'b1, 20, r, m, mo);
    chk("modified", mo, 1'b1);
  endtask
  task automatic t_pfhold;
    logic r, m, mo;
    st_pend <= 1'b1;
    st_pend_addr <= 32'h4010;
    req(32'h4020, 1'b1, 1'b0, 1, r, m, mo);
    chk("pf_hold", {r, m}, 2'b00);
    req(32'h4040, 1'b1, 1'b0, 5, r, m, mo);
    chk("pf_near", r, 1'b1);
    st_pend <= 1'b0;
  endtask
  task automatic t_combine;
    st(32'h5008, 64'h1111_2222_3333_4444, 8'hFF);
    st(32'h5010, 64'h5555_6666_7777_8888, 8'h0F);
    @(posedge mclk);
    fence_vld <= 1'b1;
    @(posedge mclk);
    fence_vld <= 1'b0;
    wait_mwr;
    chk("wc_line", mwr_line, 26'h140);
    chk("wc_be", mwr_be, 64'h0000_0000_000F_FF00);
    chk("wc_lo", mwr_data[127:64], 64'h1111_2222_3333_4444);
    chk("wc_hi", mwr_data[159:128], 32'h7777_8888);
    fence_end(0);
  endtask
  task automatic t_evict;
    wr_en <= 1'b0;
    for (int i = 0; i < 5; i++)
      st(32'h6000 + i * 64, i, 8'h01);
    wait_mwr;
    chk("evict", mwr_line, 26'h180);
    @(posedge mclk);
    wr_en <= 1'b1;
    // oldest now sits in the second buffer, not the first
    st(32'h6140, 64'h5, 8'h01);
    wait_mwr;
    chk("evict_next", mwr_line, 26'h181);
    fence_wait(4);
  endtask
  task automatic ld(input logic [31:0] a, b, input logic v0, e1);
    @(posedge mclk);
    ld0_vld <= v0;
    ld1_vld <= 1'b1;
    ld0_addr <= a;
    ld1_addr <= b;
    @(negedge mclk);
    chk("ld0_go", ld0_go, v0);
    chk("ld1_go", ld1_go, e1);
    chk("bank0", ld0_bank_sel, 8'h01 << a[5:3]);
    chk("bank1", ld1_bank_sel, 8'h01 << b[5:3]);
  endtask
  initial
  begin
    {req_vld, req_pf, req_wint, st_pend, ss_vld, fence_vld} = '0;
    {ld0_vld, ld1_vld, fill_en} = '0;
    {req_addr, st_pend_addr, ss_addr, ld0_addr, ld1_addr} = '0;
    {ss_data, ss_be} = '0;
    wr_en = 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_track;
    t_pfhold;
    t_combine;
    t_evict;
    ld(32'h0, 32'h40, 1'b1, 1'b0);
    ld(32'h0, 32'h8, 1'b1, 1'b1);
    ld(32'h100, 32'h104, 1'b1, 1'b1);
    ld(32'h108, 32'h110, 1'b1, 1'b1);
    ld(32'h38, 32'h1038, 1'b1, 1'b1);
    ld(32'h38, 32'h838, 1'b1, 1'b0);
    ld(32'h0, 32'h8, 1'b0, 1'b0);
    complete_run;
  end
endmodule
